// ---- rtl/aof_pkg.sv ----
package aof_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADC_DIS = 4'h1;
  localparam logic [3:0] REG_CMP_DIS = 4'h2;
  localparam logic [3:0] REG_STAT_E = 4'h3;
  localparam logic [3:0] REG_STAT_F = 4'h4;
  localparam logic [3:0] REG_STAT_G = 4'h5;
  // Field positions
  localparam int CTRL_PUD_BIT = 0;
  localparam int CTRL_SRE_BIT = 1;
  localparam int CMP_POS_BIT = 0;
  localparam int CMP_NEG_BIT = 1;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ADC_DIS_RST = 8'h00;
  localparam logic [7:0] CMP_DIS_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Port widths
  localparam int PE_W = 8;
  localparam int PF_W = 8;
  localparam int PG_W = 5;
endpackage : aof_pkg

// ---- rtl/aof_pin_resolve.sv ----
`timescale 1ns/1ps
module aof_pin_resolve #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] port_data,
  input wire logic [WIDTH-1:0] port_dir,
  input wire logic pullup_dis,
  input wire logic [WIDTH-1:0] pullup_override_en,
  input wire logic [WIDTH-1:0] pullup_override_val,
  input wire logic [WIDTH-1:0] dir_override_en,
  input wire logic [WIDTH-1:0] dir_override_val,
  input wire logic [WIDTH-1:0] value_override_en,
  input wire logic [WIDTH-1:0] value_override_val,
  input wire logic [WIDTH-1:0] input_enable_override_en,
  input wire logic [WIDTH-1:0] input_enable_override_val,
  output logic [WIDTH-1:0] pull_on,
  output logic [WIDTH-1:0] dir,
  output logic [WIDTH-1:0] value,
  output logic [WIDTH-1:0] in_en
);
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("aof_pin_resolve: WIDTH must be 1 to 8");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    // Plain port pull-up only on an input with its data bit set
    assign pull_on[i] = pullup_override_en[i] ? pullup_override_val[i] :
                       (port_data[i] & ~port_dir[i] & ~pullup_dis);
    assign dir[i] = dir_override_en[i] ? dir_override_val[i] : port_dir[i];
    assign value[i] = value_override_en[i] ? value_override_val[i] : port_data[i];
    assign in_en[i] = input_enable_override_en[i] ? input_enable_override_val[i] : 1'b1;
  end
endmodule : aof_pin_resolve

// ---- rtl/aof_regs.sv ----
`timescale 1ns/1ps
module aof_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [aof_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [aof_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [aof_pkg::PE_W-1:0] stat_e,
  input wire logic [aof_pkg::PF_W-1:0] stat_f,
  input wire logic [aof_pkg::PG_W-1:0] stat_g,
  output logic [aof_pkg::DATA_W-1:0] reg_rdata,
  output logic [aof_pkg::DATA_W-1:0] ctrl_q,
  output logic [aof_pkg::DATA_W-1:0] adc_dis_q,
  output logic [aof_pkg::DATA_W-1:0] cmp_dis_q
);
  logic [aof_pkg::DATA_W-1:0] rdata_q;
  logic [aof_pkg::DATA_W-1:0] rdata_d;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q <= aof_pkg::CTRL_RST;
      adc_dis_q <= aof_pkg::ADC_DIS_RST;
      cmp_dis_q <= aof_pkg::CMP_DIS_RST;
    end else if (reg_wr) begin
      if (reg_addr == aof_pkg::REG_CTRL) begin
        ctrl_q <= reg_wdata & 8'h03;
      end else if (reg_addr == aof_pkg::REG_ADC_DIS) begin
        adc_dis_q <= reg_wdata;
      end else if (reg_addr == aof_pkg::REG_CMP_DIS) begin
        cmp_dis_q <= reg_wdata & 8'h03;
      end
    end
  end

  always_comb begin
    rdata_d = aof_pkg::READ_ZERO;
    if (reg_addr == aof_pkg::REG_CTRL) begin
      rdata_d = ctrl_q;
    end else if (reg_addr == aof_pkg::REG_ADC_DIS) begin
      rdata_d = adc_dis_q;
    end else if (reg_addr == aof_pkg::REG_CMP_DIS) begin
      rdata_d = cmp_dis_q;
    end else if (reg_addr == aof_pkg::REG_STAT_E) begin
      rdata_d = stat_e;
    end else if (reg_addr == aof_pkg::REG_STAT_F) begin
      rdata_d = stat_f;
    end else if (reg_addr == aof_pkg::REG_STAT_G) begin
      rdata_d = {3'h0, stat_g};
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= aof_pkg::READ_ZERO;
    end else begin
      rdata_q <= reg_rd ? rdata_d : aof_pkg::READ_ZERO;
    end
  end

  assign reg_rdata = rdata_q;
endmodule : aof_regs

// ---- rtl/aof_pin_override.sv ----
`timescale 1ns/1ps
module aof_pin_override (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [aof_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [aof_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [aof_pkg::DATA_W-1:0] reg_rdata,
  // Port registers held elsewhere
  input wire logic [7:0] porte_data,
  input wire logic [7:0] porte_dir,
  input wire logic [7:0] portf_data,
  input wire logic [7:0] portf_dir,
  input wire logic [4:0] portg_data,
  input wire logic [4:0] portg_dir,
  // Peripheral side
  input wire logic [2:0] timer3_cmp_en,
  input wire logic timer3_compare_a_out,
  input wire logic timer3_compare_b_out,
  input wire logic timer3_compare_c_out,
  input wire logic [7:4] ext_irq_en,
  input wire logic serial0_sync_mode_select,
  input wire logic serial0_clock_out,
  input wire logic serial0_tx_enable,
  input wire logic serial0_rx_enable,
  input wire logic serial0_tx_data,
  input wire logic prog_mode,
  input wire logic prog_data_out,
  input wire logic test_port_enable,
  input wire logic instr_reg_shift_state,
  input wire logic data_reg_shift_state,
  input wire logic test_data_out,
  input wire logic timer2_async_select,
  input wire logic timer2_ext_clock,
  input wire logic ext_mem_ale,
  input wire logic ext_mem_rd,
  input wire logic ext_mem_wr,
  output logic [7:4] ext_irq_source,
  output logic timer3_capture_in,
  output logic timer3_clock_in,
  output logic serial0_ext_clock,
  output logic serial0_rx_data,
  output logic prog_data_in,
  output logic test_data_in,
  output logic test_mode_select,
  output logic test_clock,
  output logic ext_mem_enable,
  // Pads
  input wire logic [7:0] porte_pad_in,
  input wire logic [7:0] portf_pad_in,
  input wire logic [4:0] portg_pad_in,
  output logic [7:0] porte_pad_out,
  output logic [7:0] porte_pad_oe_n,
  output logic [7:0] porte_pad_pullup,
  output logic [7:0] porte_pad_ie,
  output logic [7:0] portf_pad_out,
  output logic [7:0] portf_pad_oe_n,
  output logic [7:0] portf_pad_pullup,
  output logic [7:0] portf_pad_ie,
  output logic [4:0] portg_pad_out,
  output logic [4:0] portg_pad_oe_n,
  output logic [4:0] portg_pad_pullup,
  output logic [4:0] portg_pad_ie
);
  logic [7:0] ctrl_q;
  logic [7:0] adc_dis_q;
  logic [7:0] cmp_dis_q;
  logic global_pullup_disable;
  logic [7:0] e_pullup_override_en, e_pullup_override_val, e_dir_override_en, e_dir_override_val, e_value_override_en, e_value_override_val, e_input_enable_override_en, e_input_enable_override_val;
  logic [7:0] f_pullup_override_en, f_pullup_override_val, f_dir_override_en, f_dir_override_val, f_value_override_en, f_value_override_val, f_input_enable_override_en, f_input_enable_override_val;
  logic [4:0] g_pullup_override_en, g_pullup_override_val, g_dir_override_en, g_dir_override_val, g_value_override_en, g_value_override_val, g_input_enable_override_en, g_input_enable_override_val;
  logic [7:0] e_pu, e_dir, e_val, e_ie;
  logic [7:0] f_pu, f_dir, f_val, f_ie;
  logic [4:0] g_pu, g_dir, g_val, g_ie;
  logic [7:0] e_di, f_di;

  assign global_pullup_disable = ctrl_q[aof_pkg::CTRL_PUD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  aof_regs u_regs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .stat_e(e_pullup_override_en | e_dir_override_en | e_value_override_en | e_input_enable_override_en),
    .stat_f(f_pullup_override_en | f_dir_override_en | f_value_override_en | f_input_enable_override_en),
    .stat_g(g_pullup_override_en | g_dir_override_en | g_value_override_en | g_input_enable_override_en),
    .reg_rdata(reg_rdata),
    .ctrl_q(ctrl_q),
    .adc_dis_q(adc_dis_q),
    .cmp_dis_q(cmp_dis_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Port E
  always_comb begin
    e_pullup_override_en = 8'h00;
    e_pullup_override_val = 8'h00;
    e_dir_override_en = 8'h00;
    e_dir_override_val = 8'h00;
    e_value_override_en = 8'h00;
    e_value_override_val = 8'h00;
    // Upper pins keep their buffer on for enabled interrupts
    e_input_enable_override_en = {ext_irq_en, 4'h0};
    e_input_enable_override_val = {ext_irq_en, 4'h0};
    // Direction left to software for compare outputs
    e_value_override_en[5] = timer3_cmp_en[2];
    e_value_override_val[5] = timer3_compare_c_out;
    e_value_override_en[4] = timer3_cmp_en[1];
    e_value_override_val[4] = timer3_compare_b_out;
    e_value_override_en[3] = timer3_cmp_en[0];
    e_value_override_val[3] = timer3_compare_a_out;
    e_input_enable_override_en[3] = cmp_dis_q[aof_pkg::CMP_NEG_BIT];
    e_input_enable_override_en[2] = cmp_dis_q[aof_pkg::CMP_POS_BIT];
    // Clock direction stays with the port direction bit
    e_value_override_en[2] = serial0_sync_mode_select;
    e_value_override_val[2] = serial0_clock_out;
    e_pullup_override_en[1] = serial0_tx_enable;
    e_dir_override_en[1] = serial0_tx_enable;
    e_dir_override_val[1] = 1'b1;
    e_value_override_en[1] = serial0_tx_enable;
    e_value_override_val[1] = serial0_tx_data;
    e_pullup_override_en[0] = serial0_rx_enable;
    e_pullup_override_val[0] = porte_data[0] & ~global_pullup_disable;
    e_dir_override_en[0] = serial0_rx_enable;
    // Programming download outranks the serial port
    if (prog_mode) begin
      e_pullup_override_en[1] = 1'b1;
      e_pullup_override_val[1] = 1'b0;
      e_dir_override_en[1] = 1'b1;
      e_dir_override_val[1] = 1'b1;
      e_value_override_en[1] = 1'b1;
      e_value_override_val[1] = prog_data_out;
      e_dir_override_en[0] = 1'b1;
      e_dir_override_val[0] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port F: analog inputs plus the test port on the upper four pins
  for (genvar i = 0; i < 8; i++) begin : g_portf
    if (i >= 4) begin : g_test
      assign f_pullup_override_en[i] = test_port_enable;
      assign f_pullup_override_val[i] = test_port_enable;
      assign f_dir_override_en[i] = test_port_enable;
      assign f_value_override_en[i] = test_port_enable;
      assign f_input_enable_override_en[i] = test_port_enable | adc_dis_q[i];
      if (i == 6) begin : g_tdo
        assign f_dir_override_val[i] = instr_reg_shift_state | data_reg_shift_state;
        assign f_value_override_val[i] = test_data_out;
        assign f_input_enable_override_val[i] = 1'b0;
      end else begin : g_tin
        assign f_dir_override_val[i] = 1'b0;
        assign f_value_override_val[i] = 1'b0;
        assign f_input_enable_override_val[i] = test_port_enable;
      end
    end else begin : g_adc
      assign f_pullup_override_en[i] = 1'b0;
      assign f_pullup_override_val[i] = 1'b0;
      assign f_dir_override_en[i] = 1'b0;
      assign f_dir_override_val[i] = 1'b0;
      assign f_value_override_en[i] = 1'b0;
      assign f_value_override_val[i] = 1'b0;
      assign f_input_enable_override_en[i] = adc_dis_q[i];
      assign f_input_enable_override_val[i] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port G
  always_comb begin
    g_pullup_override_en = 5'h00;
    g_pullup_override_val = 5'h00;
    g_dir_override_en = 5'h00;
    g_dir_override_val = 5'h00;
    g_value_override_en = 5'h00;
    g_value_override_val = 5'h00;
    g_input_enable_override_en = 5'h00;
    g_input_enable_override_val = 5'h00;
    g_pullup_override_en[4] = timer2_async_select;
    g_dir_override_en[4] = timer2_async_select;
    g_input_enable_override_en[4] = timer2_async_select;
    g_input_enable_override_val[4] = timer2_ext_clock;
    // Output pin is released to the crystal only with an external clock
    g_pullup_override_en[3] = timer2_async_select & timer2_ext_clock;
    g_dir_override_en[3] = timer2_async_select & timer2_ext_clock;
    g_input_enable_override_en[3] = timer2_async_select;
    g_pullup_override_en[2:0] = {3{ext_mem_enable}};
    g_dir_override_en[2:0] = {3{ext_mem_enable}};
    g_dir_override_val[2:0] = 3'h7;
    g_value_override_en[2:0] = {3{ext_mem_enable}};
    g_value_override_val[2] = ext_mem_ale;
    g_value_override_val[1] = ext_mem_rd;
    g_value_override_val[0] = ext_mem_wr;
  end

  ////////////////////////////////////////////////////////////////////////////
  aof_pin_resolve #(.WIDTH(aof_pkg::PE_W)) u_res_e (
    .port_data(porte_data),
    .port_dir(porte_dir),
    .pullup_dis(global_pullup_disable),
    .pullup_override_en(e_pullup_override_en),
    .pullup_override_val(e_pullup_override_val),
    .dir_override_en(e_dir_override_en),
    .dir_override_val(e_dir_override_val),
    .value_override_en(e_value_override_en),
    .value_override_val(e_value_override_val),
    .input_enable_override_en(e_input_enable_override_en),
    .input_enable_override_val(e_input_enable_override_val),
    .pull_on(e_pu),
    .dir(e_dir),
    .value(e_val),
    .in_en(e_ie)
  );

  aof_pin_resolve #(.WIDTH(aof_pkg::PF_W)) u_res_f (
    .port_data(portf_data),
    .port_dir(portf_dir),
    .pullup_dis(global_pullup_disable),
    .pullup_override_en(f_pullup_override_en),
    .pullup_override_val(f_pullup_override_val),
    .dir_override_en(f_dir_override_en),
    .dir_override_val(f_dir_override_val),
    .value_override_en(f_value_override_en),
    .value_override_val(f_value_override_val),
    .input_enable_override_en(f_input_enable_override_en),
    .input_enable_override_val(f_input_enable_override_val),
    .pull_on(f_pu),
    .dir(f_dir),
    .value(f_val),
    .in_en(f_ie)
  );

  aof_pin_resolve #(.WIDTH(aof_pkg::PG_W)) u_res_g (
    .port_data(portg_data),
    .port_dir(portg_dir),
    .pullup_dis(global_pullup_disable),
    .pullup_override_en(g_pullup_override_en),
    .pullup_override_val(g_pullup_override_val),
    .dir_override_en(g_dir_override_en),
    .dir_override_val(g_dir_override_val),
    .value_override_en(g_value_override_en),
    .value_override_val(g_value_override_val),
    .input_enable_override_en(g_input_enable_override_en),
    .input_enable_override_val(g_input_enable_override_val),
    .pull_on(g_pu),
    .dir(g_dir),
    .value(g_val),
    .in_en(g_ie)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pad controls; reset leaves every pin an input without pull-up
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      porte_pad_out <= 8'h00;
      porte_pad_oe_n <= 8'hFF;
      porte_pad_pullup <= 8'h00;
      porte_pad_ie <= 8'hFF;
      portf_pad_out <= 8'h00;
      portf_pad_oe_n <= 8'hFF;
      portf_pad_pullup <= 8'h00;
      portf_pad_ie <= 8'hFF;
      portg_pad_out <= 5'h00;
      portg_pad_oe_n <= 5'h1F;
      portg_pad_pullup <= 5'h00;
      portg_pad_ie <= 5'h1F;
    end else begin
      porte_pad_out <= e_val;
      porte_pad_oe_n <= ~e_dir;
      porte_pad_pullup <= e_pu;
      porte_pad_ie <= e_ie;
      portf_pad_out <= f_val;
      portf_pad_oe_n <= ~f_dir;
      portf_pad_pullup <= f_pu;
      portf_pad_ie <= f_ie;
      portg_pad_out <= g_val;
      portg_pad_oe_n <= ~g_dir;
      portg_pad_pullup <= g_pu;
      portg_pad_ie <= g_ie;
    end
  end

  // A disabled buffer reads low, so analog levels cannot toggle logic
  assign e_di = porte_pad_in & e_ie;
  assign f_di = portf_pad_in & f_ie;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ext_irq_source <= 4'h0;
      timer3_capture_in <= 1'b0;
      timer3_clock_in <= 1'b0;
      serial0_ext_clock <= 1'b0;
      serial0_rx_data <= 1'b0;
      prog_data_in <= 1'b0;
      test_data_in <= 1'b0;
      test_mode_select <= 1'b0;
      test_clock <= 1'b0;
      ext_mem_enable <= 1'b0;
    end else begin
      ext_irq_source <= e_di[7:4];
      timer3_capture_in <= e_di[7];
      timer3_clock_in <= e_di[6];
      serial0_ext_clock <= e_di[2];
      serial0_rx_data <= e_di[0];
      prog_data_in <= e_di[0];
      // Test port pins are sampled on sys_clk like the others, test clock included
      test_data_in <= f_di[7];
      test_mode_select <= f_di[5];
      test_clock <= f_di[4];
      ext_mem_enable <= ctrl_q[aof_pkg::CTRL_SRE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_cmp_value: assert property (timer3_cmp_en[0] |=>
    porte_pad_out[3] == $past(timer3_compare_a_out)
    && porte_pad_oe_n[3] == !$past(porte_dir[3])) else $error("compare A pin wrong");
  chk_irq_buffer: assert property (ext_irq_en[4] ##1 ext_irq_en[4] |=>
    porte_pad_ie[4] && ext_irq_source[4] == $past(porte_pad_in[4])) else $error("irq pin wrong");
  chk_clock_out: assert property (serial0_sync_mode_select |=>
    porte_pad_out[2] == $past(serial0_clock_out)
    && porte_pad_oe_n[2] == !$past(porte_dir[2])) else $error("serial clock pin wrong");
  chk_tx_drive: assert property (serial0_tx_enable && !prog_mode |=>
    !porte_pad_oe_n[1] && !porte_pad_pullup[1]
    && porte_pad_out[1] == $past(serial0_tx_data)) else $error("transmit pin wrong");
  chk_rx_input: assert property (serial0_rx_enable && !prog_mode |=>
    porte_pad_oe_n[0]
    && porte_pad_pullup[0] == $past(porte_data[0] & ~global_pullup_disable))
    else $error("receive pin wrong");
  chk_prog_pins: assert property (prog_mode |=>
    !porte_pad_oe_n[1] && porte_pad_oe_n[0]
    && porte_pad_out[1] == $past(prog_data_out)) else $error("programming pins wrong");
  chk_cmp_disable: assert property (cmp_dis_q[aof_pkg::CMP_NEG_BIT] |=>
    !porte_pad_ie[3]) else $error("comparator buffer on");
  chk_adc_disable: assert property (!test_port_enable |=>
    portf_pad_ie[3:0] == ~$past(adc_dis_q[3:0])) else $error("adc buffer wrong");
  chk_test_inputs: assert property (test_port_enable |=>
    portf_pad_pullup[7] && portf_pad_oe_n[5] && portf_pad_ie[4]
    && portf_pad_oe_n[7] && portf_pad_pullup[4]) else $error("test input pins wrong");
  chk_tdo_drive: assert property (test_port_enable |=>
    portf_pad_out[6] == $past(test_data_out) && !portf_pad_ie[6]
    && portf_pad_oe_n[6] == !$past(instr_reg_shift_state | data_reg_shift_state))
    else $error("test data out wrong");
  chk_osc_pins: assert property (timer2_async_select |=>
    portg_pad_oe_n[4] && !portg_pad_pullup[4] && !portg_pad_ie[3]) else $error("osc pins wrong");
  chk_xmem_pins: assert property (ext_mem_enable ##1 ext_mem_enable |->
    portg_pad_oe_n[2:0] == 3'h0 && portg_pad_pullup[2:0] == 3'h0)
    else $error("memory strobe pins wrong");
  chk_xmem_wr: assert property (ext_mem_enable |=>
    portg_pad_out[0] == $past(ext_mem_wr)) else $error("write strobe wrong");

  cov_tx_active: cover property (serial0_tx_enable ##1 !porte_pad_oe_n[1]);
  cov_tdo_shift: cover property (test_port_enable && data_reg_shift_state ##1 !portf_pad_oe_n[6]);
  cov_xmem_on: cover property (ext_mem_enable ##1 !portg_pad_oe_n[0]);
endmodule : aof_pin_override

// ---- verif/aof_pad_model.sv ----
`timescale 1ns/1ps
module aof_pad_model #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe_n,
  input wire logic [W-1:0] pad_pullup,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pad_in
);
  // Floating pin wanders, so a stale level never passes for a real one
  logic [W-1:0] float_q = '0;
  always @(posedge sys_clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!pad_oe_n[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else begin
        pad_in[i] = pad_pullup[i] | float_q[i];
      end
    end
  end
endmodule : aof_pad_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, porte_data = 8'h00, porte_dir = 8'h00;
  logic [7:0] portf_data = 8'h00, portf_dir = 8'h00, e_en = 8'h00, e_val = 8'h00;
  logic [7:0] f_en = 8'h00, f_val = 8'h00;
  logic [4:0] portg_data = 5'h00, portg_dir = 5'h00, g_en = 5'h00, g_val = 5'h00;
  logic [2:0] timer3_cmp_en = 3'h0;
  logic [7:4] ext_irq_en = 4'h0, ext_irq_source;
  logic timer3_compare_a_out = 1'b0, timer3_compare_b_out = 1'b0;
  logic timer3_compare_c_out = 1'b0, serial0_sync_mode_select = 1'b0;
  logic serial0_clock_out = 1'b0, serial0_tx_enable = 1'b0, serial0_rx_enable = 1'b0;
  logic serial0_tx_data = 1'b0, prog_mode = 1'b0, prog_data_out = 1'b0;
  logic test_port_enable = 1'b0, instr_reg_shift_state = 1'b0;
  logic data_reg_shift_state = 1'b0, test_data_out = 1'b0, timer2_async_select = 1'b0;
  logic timer2_ext_clock = 1'b0, ext_mem_ale = 1'b0, ext_mem_rd = 1'b0, ext_mem_wr = 1'b0;
  logic timer3_capture_in, timer3_clock_in, serial0_ext_clock, serial0_rx_data;
  logic prog_data_in, test_data_in, test_mode_select, test_clock, ext_mem_enable;
  logic [7:0] porte_pad_in, porte_pad_out, porte_pad_oe_n, porte_pad_pullup, porte_pad_ie;
  logic [7:0] portf_pad_in, portf_pad_out, portf_pad_oe_n, portf_pad_pullup, portf_pad_ie;
  logic [4:0] portg_pad_in, portg_pad_out, portg_pad_oe_n, portg_pad_pullup, portg_pad_ie;
  int n_fail = 0;
  int samples_checked = 0;

  always #12.5 sys_clk = ~sys_clk;

  aof_pin_override u_aof_pin_override (.*);
  aof_pad_model #(.W(8)) u_aof_pad_model_e (.sys_clk(sys_clk), .pad_out(porte_pad_out),
    .pad_oe_n(porte_pad_oe_n), .pad_pullup(porte_pad_pullup), .ext_en(e_en),
    .ext_val(e_val), .pad_in(porte_pad_in));
  aof_pad_model #(.W(8)) u_aof_pad_model_f (.sys_clk(sys_clk), .pad_out(portf_pad_out),
    .pad_oe_n(portf_pad_oe_n), .pad_pullup(portf_pad_pullup), .ext_en(f_en),
    .ext_val(f_val), .pad_in(portf_pad_in));
  aof_pad_model #(.W(5)) u_aof_pad_model_g (.sys_clk(sys_clk), .pad_out(portg_pad_out),
    .pad_oe_n(portg_pad_oe_n), .pad_pullup(portg_pad_pullup), .ext_en(g_en),
    .ext_val(g_val), .pad_in(portg_pad_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // Pad path is two registered hops plus the pad loop, so three edges
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(porte_pad_oe_n & portf_pad_ie & {3'h7, portg_pad_ie}, 8'hFF);
    chk(porte_pad_out | portf_pad_pullup | {3'h0, portg_pad_pullup}, 8'h00);
    rd(aof_pkg::REG_CTRL, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    rd(aof_pkg::REG_STAT_E, 8'h00);
  endtask : t_reset

  task automatic t_compare;
    @(posedge sys_clk);
    porte_dir <= 8'h38;
    timer3_cmp_en <= 3'h7;
    timer3_compare_a_out <= 1'b1;
    timer3_compare_c_out <= 1'b1;
    settle();
    chk(porte_pad_out & 8'h38, 8'h28);
    chk(porte_pad_oe_n & 8'h38, 8'h00);
    @(posedge sys_clk);
    porte_dir <= 8'h00;
    porte_data <= 8'h38;
    settle();
    chk(porte_pad_oe_n & porte_pad_pullup & 8'h38, 8'h38);
    chk(porte_pad_out & 8'h38, 8'h28);
    @(posedge sys_clk);
    timer3_cmp_en <= 3'h0;
    porte_data <= 8'h00;
  endtask : t_compare

  task automatic t_irq;
    @(posedge sys_clk);
    ext_irq_en <= 4'hF;
    e_en <= 8'hF0;
    e_val <= 8'hF0;
    settle();
    chk({2'h0, timer3_capture_in, timer3_clock_in, ext_irq_source}, 8'h3F);
    @(posedge sys_clk);
    e_val <= 8'h00;
    settle();
    chk({2'h0, timer3_capture_in, timer3_clock_in, ext_irq_source}, 8'h00);
    @(posedge sys_clk);
    ext_irq_en <= 4'h0;
    e_en <= 8'h00;
  endtask : t_irq

  task automatic t_serial;
    @(posedge sys_clk);
    {porte_dir, porte_data, e_en, e_val} <= {8'h05, 8'h03, 8'h01, 8'h01};
    {serial0_sync_mode_select, serial0_clock_out} <= 2'b11;
    {serial0_tx_enable, serial0_tx_data, serial0_rx_enable} <= 3'b111;
    settle();
    chk(porte_pad_out & 8'h06, 8'h06);
    chk(porte_pad_oe_n & 8'h07, 8'h01);
    chk(porte_pad_pullup & 8'h03, 8'h01);
    chk({7'h00, serial0_rx_data}, 8'h01);
    rd(aof_pkg::REG_STAT_E, 8'h07);
    wr(aof_pkg::REG_CTRL, 8'h01);
    {porte_dir, e_en, e_val, serial0_tx_data} <= {8'h01, 8'h05, 8'h04, 1'b0};
    settle();
    chk(porte_pad_pullup & 8'h03, 8'h00);
    chk(porte_pad_out & 8'h06, 8'h04);
    chk(porte_pad_oe_n & 8'h07, 8'h05);
    chk({6'h00, serial0_ext_clock, serial0_rx_data}, 8'h02);
    @(posedge sys_clk);
    {prog_mode, prog_data_out, e_val} <= {2'b11, 8'h01};
    settle();
    chk({6'h00, porte_pad_out[1], prog_data_in}, 8'h03);
    wr(aof_pkg::REG_CTRL, 8'h00);
    {porte_dir, porte_data, e_en, prog_mode, serial0_sync_mode_select} <= 26'h0;
    {serial0_tx_enable, serial0_rx_enable} <= 2'b00;
  endtask : t_serial

  task automatic t_disable;
    wr(aof_pkg::REG_CMP_DIS, 8'hFF);
    rd(aof_pkg::REG_CMP_DIS, 8'h03);
    wr(aof_pkg::REG_ADC_DIS, 8'h0F);
    rd(aof_pkg::REG_ADC_DIS, 8'h0F);
    settle();
    chk(porte_pad_ie & 8'h0C, 8'h00);
    chk(portf_pad_ie, 8'hF0);
    wr(aof_pkg::REG_CMP_DIS, 8'h00);
    settle();
    chk(porte_pad_ie & 8'h0C, 8'h0C);
  endtask : t_disable

  // Test port takes the upper Port F pins; pin 6 drives only in a shift state
  task automatic t_test_port;
    wr(aof_pkg::REG_ADC_DIS, 8'hFF);
    {portf_dir, f_en, f_val, test_port_enable, test_data_out} <= {24'hFFB0B0, 2'b11};
    settle();
    chk(portf_pad_ie, 8'hB0);
    chk(portf_pad_pullup, 8'hF0);
    chk(portf_pad_oe_n, 8'hF0);
    chk({5'h00, test_data_in, test_mode_select, test_clock}, 8'h07);
    @(posedge sys_clk);
    data_reg_shift_state <= 1'b1;
    settle();
    chk(portf_pad_oe_n, 8'hB0);
    chk(portf_pad_out, 8'h40);
    @(posedge sys_clk);
    {data_reg_shift_state, instr_reg_shift_state} <= 2'b01;
    settle();
    chk(portf_pad_oe_n, 8'hB0);
    @(posedge sys_clk);
    {instr_reg_shift_state, test_port_enable, f_en} <= 10'h0;
  endtask : t_test_port

  task automatic t_port_g;
    wr(aof_pkg::REG_CTRL, 8'h02);
    {portg_data, timer2_async_select, ext_mem_ale, ext_mem_rd, ext_mem_wr} <= 9'h1FD;
    settle();
    chk({7'h00, ext_mem_enable}, 8'h01);
    chk({3'h0, portg_pad_oe_n}, 8'h18);
    chk({3'h0, portg_pad_pullup}, 8'h08);
    chk({3'h0, portg_pad_ie}, 8'h07);
    chk({3'h0, portg_pad_out & 5'h07}, 8'h05);
    @(posedge sys_clk);
    // Every strobe flips, so a stuck pin cannot pass
    {timer2_ext_clock, ext_mem_ale, ext_mem_rd, ext_mem_wr} <= 4'b1010;
    settle();
    chk({3'h0, portg_pad_pullup}, 8'h00);
    chk({3'h0, portg_pad_ie}, 8'h17);
    chk({3'h0, portg_pad_out & 5'h07}, 8'h02);
    wr(aof_pkg::REG_CTRL, 8'h00);
    timer2_async_select <= 1'b0;
    settle();
    chk({7'h00, ext_mem_enable}, 8'h00);
    chk({3'h0, portg_pad_pullup & portg_pad_oe_n & portg_pad_ie}, 8'h1F);
  endtask : t_port_g

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_compare();
    t_irq();
    t_serial();
    t_disable();
    t_test_port();
    t_port_g();
    end_sim();
  end
endmodule : testbench
